// ===== core/ctsc_params.svh
// constants for the charge termination and system enable setup register
`ifndef CTSC_PARAMS_SVH
`define CTSC_PARAMS_SVH

`define CTSC_REG_ADDR 8'h11
`define CTSC_REG_RESET 8'h00
`define CTSC_CODE_HI 7
`define CTSC_CODE_LO 5
`define CTSC_C20_BIT 4
`define CTSC_C10_BIT 3
`define CTSC_C5_BIT 2
`define CTSC_POL_HI 1
`define CTSC_POL_LO 0
// currents in 0.5 mA steps
`define CTSC_I_CODE0 12'h019
`define CTSC_I_CODE1 12'h041
`define CTSC_I_CODE2 12'h069
`define CTSC_I_CODE3 12'h091
`define CTSC_I_CODE4 12'h0b9
`define CTSC_I_CODE5 12'h0eb
`define CTSC_I_CODE6 12'h11d
`define CTSC_I_CODE7 12'h154
`define CTSC_I_MIN 12'h019
`define CTSC_I_MAX 12'h154
`define CTSC_DIV20 12'h014
`define CTSC_DIV10 12'h00a
`define CTSC_DIV5 12'h005

`endif

// ===== core/ctsc_pkg.sv
// types for the charge termination and system enable setup block
package ctsc_pkg;

   typedef enum logic [1:0] {
      CTSC_POL_REGULATOR = 2'h0,
      CTSC_POL_BATT_NODE = 2'h1,
      CTSC_POL_WEAK_ISO = 2'h2,
      CTSC_POL_CHG_WEAK = 2'h3
   } ctsc_policy_type;

   // analog status levels, asynchronous to clk
   typedef struct packed {
      logic regulator_active;
      logic system_voltage_ok;
      logic charging_mode;
      logic charge_enable;
      logic battery_side_node_ok;
      logic battery_below_weak;
      logic input_supply_zero;
   } ctsc_status_type;

endpackage : ctsc_pkg

// ===== core/ctsc_setup.sv
// setup register for termination current and system enable policy
`timescale 1ns/1ns
`include "ctsc_params.svh"

module ctsc_setup
   import ctsc_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [11:0] charge_current_setting,
   input wire logic battery_monitor_enable,
   input wire ctsc_status_type status_pins,
   output logic [11:0] termination_current,
   output logic system_enable_output,
   output logic iso_switch_disable
);

   // ==========================================================
   // register
   logic [7:0] setup_reg;
   logic [2:0] code;
   logic c20;
   logic c10;
   logic c5;
   ctsc_policy_type policy;

   always_ff @(posedge clk) begin
      if (srst) begin
         setup_reg <= `CTSC_REG_RESET;
      end else if (reg_wr && reg_addr == `CTSC_REG_ADDR) begin
         setup_reg <= reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (reg_addr == `CTSC_REG_ADDR) begin
         reg_rdata <= setup_reg;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   assign code = setup_reg[`CTSC_CODE_HI:`CTSC_CODE_LO];
   assign c20 = setup_reg[`CTSC_C20_BIT];
   assign c10 = setup_reg[`CTSC_C10_BIT];
   assign c5 = setup_reg[`CTSC_C5_BIT];
   assign policy = ctsc_policy_type'(setup_reg[`CTSC_POL_HI:`CTSC_POL_LO]);

   // ==========================================================
   // termination current
   function automatic logic [11:0] ctsc_code_current(input logic [2:0] c);
      logic [11:0] r;
      r = `CTSC_I_CODE0;
      unique case (c)
         3'h0: r = `CTSC_I_CODE0;
         3'h1: r = `CTSC_I_CODE1;
         3'h2: r = `CTSC_I_CODE2;
         3'h3: r = `CTSC_I_CODE3;
         3'h4: r = `CTSC_I_CODE4;
         3'h5: r = `CTSC_I_CODE5;
         3'h6: r = `CTSC_I_CODE6;
         3'h7: r = `CTSC_I_CODE7;
      endcase
      return r;
   endfunction : ctsc_code_current

   function automatic logic [11:0] ctsc_clamp(input logic [11:0] v);
      logic [11:0] r;
      r = v;
      if (v < `CTSC_I_MIN) begin
         r = `CTSC_I_MIN;
      end else if (v > `CTSC_I_MAX) begin
         r = `CTSC_I_MAX;
      end
      return r;
   endfunction : ctsc_clamp

   logic [11:0] term_next;
   logic [11:0] term_reg;

   always_comb begin
      if (c20) begin
         term_next = ctsc_clamp(charge_current_setting / `CTSC_DIV20);
      end else if (c10) begin
         term_next = ctsc_clamp(charge_current_setting / `CTSC_DIV10);
      end else if (c5) begin
         term_next = ctsc_clamp(charge_current_setting / `CTSC_DIV5);
      end else begin
         term_next = ctsc_code_current(code);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         term_reg <= `CTSC_I_CODE0;
      end else begin
         term_reg <= term_next;
      end
   end

   assign termination_current = term_reg;

   // ==========================================================
   // status synchroniser, two flops before use
   ctsc_status_type sync1_reg;
   ctsc_status_type sync2_reg;

   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= status_pins;
         sync2_reg <= sync1_reg;
      end
   end

   // ==========================================================
   // system enable policy
   logic sysen_next;
   logic sysen_reg;
   logic iso_next;
   logic iso_reg;
   logic weak_iso_armed;

   assign weak_iso_armed = sync2_reg.input_supply_zero && battery_monitor_enable;

   always_comb begin
      sysen_next = 1'b0;
      iso_next = 1'b0;
      unique case (policy)
         CTSC_POL_REGULATOR: begin
            sysen_next = sync2_reg.regulator_active && sync2_reg.system_voltage_ok;
         end
         CTSC_POL_BATT_NODE: begin
            sysen_next = sync2_reg.charging_mode && sync2_reg.battery_side_node_ok;
         end
         CTSC_POL_WEAK_ISO: begin
            if (weak_iso_armed) begin
               sysen_next = sync2_reg.battery_below_weak;
               iso_next = sync2_reg.battery_below_weak;
            end else begin
               sysen_next = sync2_reg.regulator_active && sync2_reg.system_voltage_ok;
            end
         end
         CTSC_POL_CHG_WEAK: begin
            sysen_next = (sync2_reg.regulator_active && !sync2_reg.charge_enable) ||
                         (sync2_reg.charging_mode && !sync2_reg.battery_below_weak);
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sysen_reg <= 1'b0;
         iso_reg <= 1'b0;
      end else begin
         sysen_reg <= sysen_next;
         iso_reg <= iso_next;
      end
   end

   assign system_enable_output = sysen_reg;
   assign iso_switch_disable = iso_reg;

   // ==========================================================
   // checks
   default clocking ctsc_cb @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence s_write_c20;
      reg_wr && reg_addr == `CTSC_REG_ADDR && reg_wdata[`CTSC_C20_BIT];
   endsequence

   a_code_decode: assert property (
      (!c20 && !c10 && !c5) |=> term_reg == ctsc_code_current($past(code)))
      else $error("absolute termination code decoded wrongly");

   a_c20_priority: assert property (
      s_write_c20 ##1 1'b1 |=>
         term_reg == ctsc_clamp($past(charge_current_setting) / `CTSC_DIV20))
      else $error("one twentieth setting not in force");

   a_c10_priority: assert property (
      (!c20 && c10) |=> term_reg == ctsc_clamp($past(charge_current_setting) / `CTSC_DIV10))
      else $error("one tenth setting not in force");

   a_c5_priority: assert property (
      (!c20 && !c10 && c5) |=>
         term_reg == ctsc_clamp($past(charge_current_setting) / `CTSC_DIV5))
      else $error("one fifth setting not in force");

   a_clamp_range: assert property (
      $past(c20 || c10 || c5) && !$past(srst) |->
         term_reg >= `CTSC_I_MIN && term_reg <= `CTSC_I_MAX)
      else $error("fractional termination outside limits");

   a_policy_reg: assert property (
      policy == CTSC_POL_REGULATOR |=>
         sysen_reg == ($past(sync2_reg.regulator_active) && $past(sync2_reg.system_voltage_ok)))
      else $error("policy 00 enable wrong");

   a_policy_node: assert property (
      policy == CTSC_POL_BATT_NODE && sync2_reg.charging_mode && sync2_reg.battery_side_node_ok
         |=> sysen_reg)
      else $error("policy 01 enable missing");

   a_weak_iso: assert property (
      policy == CTSC_POL_WEAK_ISO && weak_iso_armed && sync2_reg.battery_below_weak
         |=> sysen_reg && iso_reg)
      else $error("policy 10 weak battery response missing");

   a_chg_weak: assert property (
      policy == CTSC_POL_CHG_WEAK && !sync2_reg.regulator_active && sync2_reg.battery_below_weak
         |=> !sysen_reg)
      else $error("policy 11 enabled below weak threshold");

   a_iso_guard: assert property (
      iso_reg |-> $past(policy == CTSC_POL_WEAK_ISO && weak_iso_armed))
      else $error("isolation disabled without supply at zero and monitor on");

   // pins rise, two sync flops, then the output flop: high on the third edge
   a_sync_delay: assert property (
      (policy == CTSC_POL_REGULATOR) [*3] ##0
         $rose(status_pins.regulator_active && status_pins.system_voltage_ok) ##1
         ($stable(status_pins) && policy == CTSC_POL_REGULATOR) [*2] |=> sysen_reg)
      else $error("synchronised enable late");

endmodule : ctsc_setup

// ===== sim/ctsc_host_model.sv
// host side model that writes the setup register and holds the read address
`timescale 1ns/1ns

module ctsc_host_model (
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
   end

   // one-cycle write strobe; the address stays put afterwards so it selects read data
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      // released data lines must not keep showing the last value
      reg_wdata = ~d;
   endtask : wr
endmodule : ctsc_host_model

// ===== sim/charge_termination_sysen_config_tb.sv
// self-checking bench for the termination and system enable setup register
`timescale 1ns/1ns

module charge_termination_sysen_config_tb;
   import ctsc_pkg::*;
   logic clk, srst, mon, chk, reg_wr, sysen, iso, e, i;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [11:0] chg_cur, term;
   ctsc_status_type st;
   logic [13:0] exp_q[$];
   int fails, compares;
   int unsigned lvl[8] = '{25, 65, 105, 145, 185, 235, 285, 340};
   string nm[4] = '{"reg_rdata", "termination_current", "system_enable_output", "iso_switch"};

   ctsc_host_model i_ctsc_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata));
   ctsc_setup i_ctsc_setup (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .charge_current_setting(chg_cur),
      .battery_monitor_enable(mon), .status_pins(st), .termination_current(term),
      .system_enable_output(sysen), .iso_switch_disable(iso));

   // ==========================================
   // expectations, in 0.5 mA units
   function automatic logic [11:0] exp_term(input logic [7:0] r, input logic [11:0] c);
      int unsigned v;
      if (r[4]) v = c / 20;
      else if (r[3]) v = c / 10;
      else if (r[2]) v = c / 5;
      else return lvl[r[7:5]][11:0];
      if (v < 25) v = 25;
      if (v > 340) v = 340;
      return v[11:0];
   endfunction : exp_term

   task automatic note(input logic [1:0] s, input logic [11:0] v);
      @(negedge clk);
      exp_q.push_back({s, v});
      chk = 1'b1;
   endtask : note

   task automatic end_of_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test

   // ==========================================
   // monitor: oldest note against the selected output
   always @(posedge clk) begin
      logic [13:0] x;
      logic [11:0] seen;
      if (chk) begin
         x = exp_q.pop_front();
         // look once the edge has settled, not in its own time step
         #1;
         case (x[13:12])
            2'h0: seen = {4'h0, reg_rdata};
            2'h1: seen = term;
            2'h2: seen = {11'h0, sysen};
            default: seen = {11'h0, iso};
         endcase
         compares++;
         if (seen !== x[11:0]) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm[x[13:12]], x[11:0], seen);
         end
      end
   end

   // ==========================================
   // clock, watchdog and main sequence
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      end_of_test();
   end

   initial begin
      srst = 1'b1;
      mon = 1'b0;
      chk = 1'b0;
      chg_cur = 12'h000;
      st = '0;
      void'($urandom(32'h9d13));
      repeat (2) @(posedge clk);
      @(negedge clk);
      srst = 1'b0;
      repeat (3) @(negedge clk);
      note(2'h1, 12'h019);
      note(2'h2, 12'h000);
      note(2'h0, 12'h000);
      note(2'h3, 12'h000);
      // status rise under policy 00: enable follows on the third edge
      @(negedge clk);
      chk = 1'b0;
      st = ctsc_status_type'(7'h60);
      note(2'h2, 12'h000);
      note(2'h2, 12'h001);
      // policy 10 armed with weak battery, then above weak, then monitor off
      @(negedge clk);
      chk = 1'b0;
      mon = 1'b1;
      st = ctsc_status_type'(7'h03);
      i_ctsc_host_model.wr(8'h11, 8'h02);
      repeat (3) @(negedge clk);
      note(2'h2, 12'h001);
      note(2'h3, 12'h001);
      @(negedge clk);
      chk = 1'b0;
      st = ctsc_status_type'(7'h01);
      repeat (3) @(negedge clk);
      note(2'h2, 12'h000);
      note(2'h3, 12'h000);
      @(negedge clk);
      chk = 1'b0;
      mon = 1'b0;
      st = ctsc_status_type'(7'h03);
      repeat (3) @(negedge clk);
      note(2'h2, 12'h000);
      note(2'h3, 12'h000);
      for (int n = 0; n < 64; n++) begin
         @(negedge clk);
         chk = 1'b0;
         chg_cur = 12'($urandom_range(4095));
         mon = 1'($urandom);
         st = ctsc_status_type'($urandom);
         d = 8'($urandom);
         if (n % 2 == 0) d[4:2] = 3'h0;
         i_ctsc_host_model.wr(8'h11, d);
         repeat (3) @(negedge clk);
         case (d[1:0])
            2'h0: e = st.regulator_active & st.system_voltage_ok;
            2'h1: e = st.charging_mode & st.battery_side_node_ok;
            2'h2: e = (st.input_supply_zero & mon) ? st.battery_below_weak :
               (st.regulator_active & st.system_voltage_ok);
            default: e = (st.regulator_active & ~st.charge_enable) |
               (st.charging_mode & ~st.battery_below_weak);
         endcase
         i = (d[1:0] == 2'h2) & st.input_supply_zero & mon & st.battery_below_weak;
         note(2'h0, {4'h0, d});
         note(2'h1, exp_term(d, chg_cur));
         note(2'h2, {11'h0, e});
         note(2'h3, {11'h0, i});
         if (n % 8 == 7) begin
            @(negedge clk);
            chk = 1'b0;
            i_ctsc_host_model.wr(8'h12, ~d);
            repeat (2) @(negedge clk);
            note(2'h0, 12'h000);
            note(2'h1, exp_term(d, chg_cur));
         end
      end
      @(negedge clk);
      chk = 1'b0;
      repeat (2) @(negedge clk);
      end_of_test();
   end
endmodule : charge_termination_sysen_config_tb
